// ==== hdl/bsram_map.svh ====
// constants for the burst synchronous static ram and its controller
`ifndef BSRAM_MAP_SVH
`define BSRAM_MAP_SVH
`define BSRAM_ADDR_W 16
`define BSRAM_DATA_W 32
`define BSRAM_LANES 4
`define BSRAM_LANE_W 8
`define BSRAM_BURST_LEN 3'h4
`define BSRAM_WORDS 65536
// controller register offsets
`define BSRAM_REG_CMD 4'h0
`define BSRAM_REG_ADDR 4'h1
`define BSRAM_REG_WDATA 4'h2
`define BSRAM_REG_RDATA 4'h3
`define BSRAM_REG_STAT 4'h4
`define BSRAM_REG_CFG 4'h5
// command and config field positions
`define BSRAM_CMD_WR_BIT 0
`define BSRAM_CMD_GLOBAL_BIT 1
`define BSRAM_CMD_LANE_LSB 4
`define BSRAM_CMD_LEN_LSB 8
`define BSRAM_CFG_ORDER_BIT 0
`define BSRAM_CFG_SLEEP_BIT 1
`endif

// ==== hdl/bsram_pkg.sv ====
// types used by the controller end of the burst synchronous static ram link
package bsram_pkg;
	typedef logic [15:0] bsram_addr_t;
	typedef logic [31:0] bsram_data_t;
	typedef logic [3:0] bsram_lane_t;
	typedef enum logic [2:0]
	{
		BSRAM_IDLE = 3'b000,
		BSRAM_START = 3'b001,
		BSRAM_HOLD = 3'b010,
		BSRAM_STEP = 3'b011,
		BSRAM_DRAIN = 3'b100
	} bsram_state_t;
endpackage

// ==== hdl/bsram_if.sv ====
// pin-level link between the static ram and its controller
`timescale 1ns/1ps
`default_nettype none
interface bsram_if;
	logic [15:0] addr;
	logic cpu_addr_strobe_n;
	logic ctrl_addr_strobe_n;
	logic burst_step_n;
	logic chip_sel_n;
	logic chip_sel_hi;
	logic chip_sel2_n;
	logic global_write_n;
	logic byte_write_gate_n;
	logic [3:0] byte_lane_write_n;
	logic out_en_n;
	logic sleep_req;
	logic burst_order;
	logic test_tie_low;
	logic [31:0] data_o_ctl;
	logic data_oe_n_ctl;
	logic [31:0] data_o_mem;
	logic data_oe_n_mem;
	logic [31:0] data_io;
	// resolved data bus: whoever has its enable low drives it, the memory if both do
	always_comb
	begin
		if (!data_oe_n_mem)
			data_io = data_o_mem;
		else if (!data_oe_n_ctl)
			data_io = data_o_ctl;
		else
			data_io = 32'hFFFF_FFFF;
	end
	modport mem (input addr, cpu_addr_strobe_n, ctrl_addr_strobe_n,
		burst_step_n, chip_sel_n, chip_sel_hi, chip_sel2_n, global_write_n,
		byte_write_gate_n, byte_lane_write_n, out_en_n, sleep_req,
		burst_order, test_tie_low, data_io,
		output data_o_mem, data_oe_n_mem);
	modport ctl (output addr, cpu_addr_strobe_n, ctrl_addr_strobe_n,
		burst_step_n, chip_sel_n, chip_sel_hi, chip_sel2_n, global_write_n,
		byte_write_gate_n, byte_lane_write_n, out_en_n, sleep_req,
		burst_order, test_tie_low, data_o_ctl, data_oe_n_ctl,
		input data_io);
endinterface
`default_nettype wire

// ==== hdl/bsram_mem.sv ====
// burst synchronous static ram: 64k words of 32 bits with burst counter
`include "bsram_map.svh"
`timescale 1ns/1ps
`default_nettype none
module bsram_mem #(
	parameter int WORDS = `BSRAM_WORDS
)(
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	bsram_if.mem LINK
);
	// -----------------------------------------------------------------
	// parameter checks
	// -----------------------------------------------------------------
	// the decode and burst counter serve exactly this depth and word
	generate
		if (WORDS != `BSRAM_WORDS)
		begin : g_bad_depth
			$error("bsram_mem: unsupported array depth");
		end
		if (`BSRAM_LANES * `BSRAM_LANE_W != `BSRAM_DATA_W)
		begin : g_bad_lanes
			$error("bsram_mem: lanes do not cover the data word");
		end
	endgenerate
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] base;  // captured external address
		logic [1:0] start;  // low bits at burst start
		logic [1:0] count;  // words stepped in the burst
		logic active;       // a burst has been started
		logic rd_live;      // current cycle is a read
		logic [31:0] rdata;
	} bsram_mem_st_t;
	bsram_mem_st_t st_r;
	bsram_mem_st_t st_nxt;
	wire [31:0] rd_word; // word read from the lane stores
	logic drive_rd;
	logic sel_ok;
	logic cpu_go;
	logic ctl_go;
	logic wr_req;
	logic [3:0] lane_we;
	logic [1:0] low_bits;
	logic [15:0] acc_addr;
	logic do_write;
	logic [1:0] cnt_next;
	// -----------------------------------------------------------------
	// decode of the sampled controls
	// -----------------------------------------------------------------
	always_comb
	begin
		// all three selects active, and which strobe may start a cycle
		sel_ok = !LINK.chip_sel_n && LINK.chip_sel_hi && !LINK.chip_sel2_n;
		cpu_go = !LINK.cpu_addr_strobe_n && !LINK.chip_sel_n;
		ctl_go = LINK.cpu_addr_strobe_n && !LINK.ctrl_addr_strobe_n;
		// global write overrides the byte gate and lanes
		if (!LINK.global_write_n)
			lane_we = 4'hF;
		else if (!LINK.byte_write_gate_n)
			lane_we = ~LINK.byte_lane_write_n;
		else
			lane_we = 4'h0;
		wr_req = |lane_we;
	end
	// -----------------------------------------------------------------
	// next-state: burst start, step, suspend, deselect
	// -----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		do_write = 1'b0;
		// the pins go quiet unless this cycle reads
		st_nxt.rd_live = 1'b0;
		// sleep: no access at all
		if (LINK.sleep_req)
		begin
			st_nxt.rd_live = 1'b0; // sleep forces the data pins off
		end
		else if (cpu_go || ctl_go)
		begin
			if ((cpu_go && sel_ok) || (ctl_go && sel_ok))
			begin
				st_nxt.base = LINK.addr;
				st_nxt.start = LINK.addr[1:0];
				st_nxt.count = 2'h0;
				st_nxt.active = 1'b1;
				st_nxt.rd_live = cpu_go || !wr_req;
				do_write = ctl_go && wr_req;
			end
			else
			begin
				// a select inactive: the strobe performs no access
				st_nxt.active = 1'b0;
			end
		end
		else if (!LINK.ctrl_addr_strobe_n)
		begin
			// controller strobe with the primary select high
			st_nxt.active = 1'b0;
		end
		else if (st_r.active)
		begin
			// both strobes high: next or current burst word
			st_nxt.count = cnt_next;
			st_nxt.rd_live = !wr_req;
			do_write = wr_req;
		end
	end
	// -----------------------------------------------------------------
	// burst counter: steps on advance low, holds otherwise
	// -----------------------------------------------------------------
	// only the low two bits count, so a fourth step wraps to the start
	always_comb
	begin
		cnt_next = st_r.count;
		if (!LINK.burst_step_n)
			cnt_next = st_r.count + 2'h1;
	end
	// -----------------------------------------------------------------
	// burst address: linear adds, interleaved xors
	// -----------------------------------------------------------------
	always_comb
	begin
		if (LINK.burst_order)
			low_bits = st_nxt.start ^ st_nxt.count;
		else
			low_bits = st_nxt.start + st_nxt.count;
		acc_addr = {st_nxt.base[15:2], low_bits};
	end
	// -----------------------------------------------------------------
	// registers and array; writes finish inside the sampling cycle
	// -----------------------------------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			st_r <= '0; // data pins off from power-up
		end
		else
		begin
			st_r <= st_nxt;
			st_r.rdata <= rd_word;
		end
	end
	// -----------------------------------------------------------------
	// array: one byte-wide store per lane
	// -----------------------------------------------------------------
	// each lane owns its store, so no two processes write one array;
	// a read and a write never share an edge, so no bypass is needed
	genvar g;
	generate
		for (g = 0; g < `BSRAM_LANES; g = g + 1)
		begin : g_lane
			logic [`BSRAM_LANE_W-1:0] lane_r [0:WORDS-1];
			// lane g covers data bits 8g..8g+7
			always_ff @(posedge CLK_SYS)
			begin
				if (!SYS_RST && do_write && lane_we[g])
					lane_r[acc_addr] <= LINK.data_io[g*`BSRAM_LANE_W +:
						`BSRAM_LANE_W];
			end
			// read side of the lane
			assign rd_word[g*`BSRAM_LANE_W +: `BSRAM_LANE_W] =
				lane_r[acc_addr];
		end
	endgenerate
	// -----------------------------------------------------------------
	// data pins: registered read data, enable gated asynchronously
	// -----------------------------------------------------------------
	assign LINK.data_o_mem = st_r.rdata;
	// read flag, async enable and sleep gate the drivers
	always_comb
	begin
		drive_rd = st_r.rd_live && !LINK.out_en_n && !LINK.sleep_req;
	end
	// the enable terms are not registered, so the pins follow at once
	assign LINK.data_oe_n_mem = !drive_rd;
endmodule // bsram_mem
`default_nettype wire

// ==== hdl/bsram_ctl.sv ====
// controller end: turns register commands into burst cycles on the link
//
// The register offsets and strobed register access are this design's own decisions.
`include "bsram_map.svh"
`timescale 1ns/1ps
`default_nettype none
module bsram_ctl (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	bsram_if.ctl LINK
);
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		bsram_pkg::bsram_state_t state;
		logic [15:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [3:0] lanes;
		logic wr;
		logic glob;
		logic [2:0] left;    // words still to move
		logic order;
		logic sleep;
		logic busy;
		logic [31:0] rbus;
		logic [31:0] pin_wd;
		logic pin_oe_n;
		logic cpu_n;
		logic ctl_n;
		logic step_n;
		logic gw_n;
		logic bwe_n;
		logic [3:0] bw_n;
		logic oe_n;
	} bsram_ctl_st_t;
	bsram_ctl_st_t st_r;
	bsram_ctl_st_t st_nxt;
	// -----------------------------------------------------------------
	// command decode and link sequencing
	// -----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.cpu_n = 1'b1;
		st_nxt.ctl_n = 1'b1;
		st_nxt.step_n = 1'b1;
		st_nxt.gw_n = 1'b1;
		st_nxt.bwe_n = 1'b1;
		st_nxt.bw_n = 4'hF;
		st_nxt.pin_oe_n = 1'b1;
		st_nxt.oe_n = 1'b1; // stays high around writes
		st_nxt.rbus = 32'h0000_0000;
		if (REG_RD)
		begin
			case (REG_ADDR)
				`BSRAM_REG_ADDR: st_nxt.rbus = {16'h0000, st_r.addr};
				`BSRAM_REG_WDATA: st_nxt.rbus = st_r.wdata;
				`BSRAM_REG_RDATA: st_nxt.rbus = st_r.rdata;
				`BSRAM_REG_STAT: st_nxt.rbus = {31'h0000_0000, st_r.busy};
				`BSRAM_REG_CFG: st_nxt.rbus = {30'h0000_0000, st_r.sleep,
					st_r.order};
				default: st_nxt.rbus = 32'h0000_0000;
			endcase
		end
		if (REG_WR)
		begin
			case (REG_ADDR)
				`BSRAM_REG_ADDR: st_nxt.addr = REG_WDATA[15:0];
				`BSRAM_REG_WDATA: st_nxt.wdata = REG_WDATA;
				`BSRAM_REG_CFG:
				begin
					st_nxt.order = REG_WDATA[`BSRAM_CFG_ORDER_BIT];
					st_nxt.sleep = REG_WDATA[`BSRAM_CFG_SLEEP_BIT];
				end
				`BSRAM_REG_CMD:
				begin
					if (!st_r.busy)
					begin
						st_nxt.wr = REG_WDATA[`BSRAM_CMD_WR_BIT];
						st_nxt.glob = REG_WDATA[`BSRAM_CMD_GLOBAL_BIT];
						st_nxt.lanes = REG_WDATA[`BSRAM_CMD_LANE_LSB +: 4];
						st_nxt.left = REG_WDATA[`BSRAM_CMD_LEN_LSB +: 3];
						if (REG_WDATA[`BSRAM_CMD_LEN_LSB +: 3] == 3'h0
							|| REG_WDATA[`BSRAM_CMD_LEN_LSB +: 3] > `BSRAM_BURST_LEN)
							st_nxt.left = 3'h1;
						st_nxt.busy = 1'b1;
						st_nxt.state = bsram_pkg::BSRAM_START;
					end
				end
				default: ;
			endcase
		end
		case (st_r.state)
			bsram_pkg::BSRAM_IDLE: ;
			bsram_pkg::BSRAM_START:
			begin
				// read via cpu strobe; write via controller strobe
				st_nxt.cpu_n = st_r.wr;
				st_nxt.ctl_n = !st_r.wr;
				if (st_r.wr)
				begin
					st_nxt.gw_n = !st_r.glob;
					st_nxt.bwe_n = st_r.glob;
					st_nxt.bw_n = ~st_r.lanes;
					st_nxt.pin_wd = st_r.wdata;
					st_nxt.pin_oe_n = 1'b0;
				end
				st_nxt.left = st_r.left - 3'h1;
				st_nxt.state = bsram_pkg::BSRAM_HOLD;
			end
			bsram_pkg::BSRAM_HOLD:
			begin
				// first edge after a start keeps advance high
				st_nxt.oe_n = st_r.wr; // memory drives the next cycle
				st_nxt.state = (st_r.left == 3'h0) ? bsram_pkg::BSRAM_DRAIN
					: bsram_pkg::BSRAM_STEP;
			end
			bsram_pkg::BSRAM_STEP:
			begin
				// take the word that the memory drives this cycle
				if (!st_r.wr)
					st_nxt.rdata = LINK.data_io;
				st_nxt.step_n = 1'b0;
				if (st_r.wr)
				begin
					st_nxt.gw_n = !st_r.glob;
					st_nxt.bwe_n = st_r.glob;
					st_nxt.bw_n = ~st_r.lanes;
					st_nxt.pin_wd = st_r.wdata;
					st_nxt.pin_oe_n = 1'b0;
				end
				st_nxt.left = st_r.left - 3'h1;
				st_nxt.state = bsram_pkg::BSRAM_HOLD;
			end
			bsram_pkg::BSRAM_DRAIN:
			begin
				// last word of a read stands on the bus this cycle
				if (!st_r.wr)
					st_nxt.rdata = LINK.data_io;
				st_nxt.busy = 1'b0;
				st_nxt.state = bsram_pkg::BSRAM_IDLE;
			end
			default: st_nxt.state = bsram_pkg::BSRAM_IDLE;
		endcase
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			st_r <= '0;
			st_r.order <= 1'b1;
			st_r.cpu_n <= 1'b1;
			st_r.ctl_n <= 1'b1;
			st_r.step_n <= 1'b1;
			st_r.gw_n <= 1'b1;
			st_r.bwe_n <= 1'b1;
			st_r.bw_n <= 4'hF;
			st_r.oe_n <= 1'b1;
			st_r.pin_oe_n <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end
	// -----------------------------------------------------------------
	// pins
	// -----------------------------------------------------------------
	assign REG_RDATA = st_r.rbus;
	assign LINK.addr = st_r.addr;
	assign LINK.cpu_addr_strobe_n = st_r.cpu_n;
	assign LINK.ctrl_addr_strobe_n = st_r.ctl_n;
	assign LINK.burst_step_n = st_r.step_n;
	assign LINK.chip_sel_n = 1'b0;
	assign LINK.chip_sel_hi = 1'b1;
	assign LINK.chip_sel2_n = 1'b0;
	assign LINK.global_write_n = st_r.gw_n;
	assign LINK.byte_write_gate_n = st_r.bwe_n;
	assign LINK.byte_lane_write_n = st_r.bw_n;
	assign LINK.out_en_n = st_r.oe_n;
	assign LINK.sleep_req = st_r.sleep;
	assign LINK.burst_order = st_r.order; // set by the cfg order bit
	assign LINK.test_tie_low = 1'b0;
	assign LINK.data_o_ctl = st_r.pin_wd;
	assign LINK.data_oe_n_ctl = st_r.pin_oe_n;
endmodule // bsram_ctl
`default_nettype wire

// ==== verification/bsram_monitor.sv ====
// concurrent checks on the link between the static ram and its controller
`timescale 1ns/1ps
`default_nettype none
module bsram_monitor (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic cpu_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic chip_sel_n,
	input wire logic chip_sel_hi,
	input wire logic chip_sel2_n,
	input wire logic global_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [3:0] byte_lane_write_n,
	input wire logic out_en_n,
	input wire logic sleep_req,
	input wire logic burst_order,
	input wire logic test_tie_low,
	input wire logic data_oe_n_ctl,
	input wire logic data_oe_n_mem
);
	// ----------------------------------------
	// decoded link state
	// ----------------------------------------
	logic wr_req;
	logic sel_ok;
	assign wr_req = !global_write_n
		|| (!byte_write_gate_n && byte_lane_write_n != 4'hF);
	assign sel_ok = !chip_sel_n && chip_sel_hi && !chip_sel2_n;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_tie_low: assert property (test_tie_low == 1'h0)
		else $error("test tie input not low");
	a_order_static: assert property (
		(!cpu_addr_strobe_n || !ctrl_addr_strobe_n) |-> $stable(burst_order))
		else $error("burst order changed during access");
	a_sleep_quiet: assert property (
		sleep_req |-> data_oe_n_mem)
		else $error("memory drives data while asleep");
	a_oe_async: assert property (
		out_en_n |-> data_oe_n_mem)
		else $error("memory drives data with output enable high");
	a_power_quiet: assert property (
		$fell(SYS_RST) |-> data_oe_n_mem [*2])
		else $error("memory drives data right after power up");
	a_write_quiet: assert property (
		(!ctrl_addr_strobe_n && cpu_addr_strobe_n && sel_ok && wr_req)
		|=> data_oe_n_mem)
		else $error("memory drives data in a write");
	a_read_drives: assert property (
		(!cpu_addr_strobe_n && sel_ok)
		|=> (out_en_n || sleep_req || !data_oe_n_mem))
		else $error("read start gave no data");
	a_no_clash: assert property (
		data_oe_n_mem || data_oe_n_ctl)
		else $error("both ends drive the data bus");
endmodule // bsram_monitor
`default_nettype wire

// ==== verification/tb_burst_sync_sram_64kx32.sv ====
// self-checking bench for the burst static ram and its controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("ERROR t=%0t got %h exp %h", $time, got, exp); \
		end \
	end
module tb_burst_sync_sram_64kx32;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic [31:0] seed = 32'h0000_EC60;
	logic ord = 1'h1;
	logic [31:0] model [int];
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;
	bsram_if link ();
	bsram_ctl u_bsram_ctl (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LINK(link));
	bsram_mem u_bsram_mem (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .LINK(link));
	bsram_monitor u_bsram_monitor (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
		.cpu_addr_strobe_n(link.cpu_addr_strobe_n),
		.ctrl_addr_strobe_n(link.ctrl_addr_strobe_n),
		.chip_sel_n(link.chip_sel_n), .chip_sel_hi(link.chip_sel_hi),
		.chip_sel2_n(link.chip_sel2_n), .global_write_n(link.global_write_n),
		.byte_write_gate_n(link.byte_write_gate_n),
		.byte_lane_write_n(link.byte_lane_write_n), .out_en_n(link.out_en_n),
		.sleep_req(link.sleep_req), .burst_order(link.burst_order),
		.test_tie_low(link.test_tie_low), .data_oe_n_ctl(link.data_oe_n_ctl),
		.data_oe_n_mem(link.data_oe_n_mem));
	// clock, and a ceiling on run length
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			err_total++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// burst address of word k: xor count when interleaved, add when linear
	function automatic logic [15:0] baddr(input logic [15:0] a, input int k,
		input logic o);
		logic [1:0] lo;
		lo = o ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
		return {a[15:2], lo};
	endfunction
	task automatic print_verdict();
		$display("tests_run %0d err_total %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	// one burst through the controller, mirrored in the model
	task automatic xfer(input logic [15:0] a, input logic [3:0] lanes,
		input logic glob, input logic wr, input int len);
		logic [31:0] d;
		logic [31:0] s;
		logic [15:0] b;
		int n;
		seed = lfsr(seed);
		d = seed;
		reg_write(4'h1, {16'h0000, a});
		reg_write(4'h2, d);
		reg_write(4'h0, {21'h0, len[2:0], lanes, 2'h0, glob, wr});
		repeat (2) @(posedge clk_sys);
		s = 32'h0000_0001;
		for (n = 0; n < 100 && s[0]; n++)
			reg_read(4'h4, s);
		if (s[0])
		begin
			err_total++;
			$display("ERROR t=%0t busy stuck %h exp %h", $time, s, 32'h0);
		end
		for (int k = 0; k < len; k++)
		begin
			b = baddr(a, k, ord);
			for (int i = 0; i < 4 && wr; i++)
				if (glob || lanes[i])
					model[b][8*i +: 8] = d[8*i +: 8];
		end
		if (!wr)
		begin
			reg_read(4'h3, d);
			`CHK(d, model[b])
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] r;
		logic [15:0] base;
		logic [3:0] ln;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'h0;
		reg_read(4'h5, r);
		`CHK(r[0], 1'h1)
		reg_read(4'hF, r);
		`CHK(r, 32'h0000_0000)
		for (int o = 1; o >= 0; o--)
		begin
			ord = o[0];
			reg_write(4'h5, {31'h0, ord});
			for (int s = 0; s < 4; s++)
			begin
				seed = lfsr(seed);
				base = {seed[15:2], s[1:0]};
				ln = (seed[19:16] == 4'h0) ? 4'h8 : seed[19:16];
				for (int w = 0; w < 4; w++)
					xfer(baddr(base, w, 1'h1), 4'h0, 1'h1, 1'h1, 1);
				for (int n = 1; n <= 4; n++)
					xfer(base, 4'h0, 1'h0, 1'h0, n);
				xfer(base, ln, 1'h0, 1'h1, 2);
				for (int w = 0; w < 4; w++)
					xfer(baddr(base, w, 1'h1), 4'h0, 1'h0, 1'h0, 1);
				xfer(base, ln, 1'h1, 1'h1, 3);
				for (int n = 1; n <= 4; n++)
					xfer(base, 4'h0, 1'h0, 1'h0, n);
				$display("order %0d start %0d done, errors %0d", o, s,
					err_total);
			end
		end
		// asleep, a read finds the bus undriven, which idles at all ones
		reg_write(4'h5, {30'h0, 1'h1, ord});
		reg_write(4'h0, 32'h0000_0100);
		repeat (12) @(posedge clk_sys);
		reg_read(4'h3, r);
		`CHK(r, 32'hFFFF_FFFF)
		// awake again, the stored word must still read back
		reg_write(4'h5, {31'h0, ord});
		xfer(base, 4'h0, 1'h0, 1'h0, 1);
		$display("sleep test done, errors %0d", err_total);
		print_verdict();
	end
endmodule // tb_burst_sync_sram_64kx32
`default_nettype wire
